// ---- flash_host.sv ----
// host controller driving a quad serial flash for program, erase and power-down
//
// Summary of operation
// - quad page program is sent only after reading quad enable set.
// - program frame is opcode 32h, three address bytes, data on four pins.
// - a write enable frame always precedes every program or erase frame.
// - chip select rises only after the eighth bit of last data byte.
// - sector erase is opcode 20h with three address bytes.
// - sector erase frame ends right after the last address bit.
// - 32KB block erase is opcode 52h with three address bytes.
// - 64KB block erase is opcode d8h with three address bytes.
// - block erase frames end right after the last address bit.
// - chip erase is opcode 60h or c7h alone, ended after bit eight.
// - deep sleep is b9h alone; host then waits the entry delay.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_host
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // flash pins
  output var flash_host_pkg::pins_t pins,
  input wire logic [3:0] io_i
);

  typedef enum logic [2:0] {SQ_IDLE, SQ_QE, SQ_WRITE_ENABLE_COMMAND, SQ_MAIN, SQ_POLL, SQ_WAIT} seq_t;
  typedef enum logic [1:0] {FR_IDLE, FR_SEL, FR_SHIFT, FR_GAP} fr_t;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  function automatic flash_host_pkg::frame_t mk(input logic [7:0] opc, input logic a,
    input logic [8:0] n, input logic r);
    flash_host_pkg::frame_t f;
    f.opcode = opc;
    f.has_addr = a;
    f.n_data = n;
    f.rd = r;
    return f;
  endfunction

  function automatic logic [9:0] frame_len(input flash_host_pkg::frame_t f);
    return 10'd1 + (f.has_addr ? 10'd3 : 10'd0) + {1'b0, f.n_data} + {9'h0, f.rd};
  endfunction

  function automatic logic [9:0] hdr_len(input flash_host_pkg::frame_t f);
    return f.has_addr ? 10'd4 : 10'd1;
  endfunction

  // ************************************************************
  // divider and pin synchroniser
  // ************************************************************
  logic [2:0] div_r, div_nxt;
  logic tick;
  logic io1_s1_r, io1_s2_r;

  always_comb
  begin
    tick = (div_r == flash_host_pkg::SCLK_HALF_CYC - 3'h1);
    div_nxt = tick ? 3'h0 : div_r + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= 3'h0;
      io1_s1_r <= 1'b0;
      io1_s2_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      io1_s1_r <= io_i[1];
      io1_s2_r <= io1_s1_r;
    end
  end

  // ************************************************************
  // registers written by software
  // ************************************************************
  logic [7:0] mem [0:255];
  logic [23:0] addr_r, addr_nxt;
  logic [8:0] len_r, len_nxt;
  logic [8:0] wptr_r, wptr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rd_ack_r, rd_ack_nxt;
  logic busy, wr_ok, cmd_go;
  seq_t seq_r, seq_nxt;
  flash_host_pkg::op_t op_r, op_nxt;
  logic alt_r, alt_nxt, asleep_r, asleep_nxt, refused_r, refused_nxt;
  logic [7:0] status_r, status_nxt;

  always_comb
  begin
    busy = (seq_r != SQ_IDLE);
    wr_ok = avs_write && !busy;
    cmd_go = wr_ok && (avs_address == flash_host_pkg::REG_CTRL);
    avs_waitrequest = (avs_read && !rd_ack_r) || (avs_write && busy);
    avs_readdata = rdata_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    wptr_nxt = wptr_r;
    rd_ack_nxt = avs_read && !rd_ack_r;
    rdata_nxt = rdata_r;
    if (wr_ok && avs_address == flash_host_pkg::REG_ADDR)
      addr_nxt = avs_writedata[23:0];
    if (wr_ok && avs_address == flash_host_pkg::REG_LEN)
    begin
      len_nxt = avs_writedata[8:0];
      wptr_nxt = 9'h0;
    end
    if (wr_ok && avs_address == flash_host_pkg::REG_DATA && wptr_r != 9'h100)
      wptr_nxt = wptr_r + 9'h1;
    if (avs_read && !rd_ack_r)
    begin
      unique case (avs_address)
        flash_host_pkg::REG_CTRL: rdata_nxt = {28'h0, alt_r, op_r};
        flash_host_pkg::REG_ADDR: rdata_nxt = {8'h0, addr_r};
        flash_host_pkg::REG_LEN: rdata_nxt = {23'h0, len_r};
        flash_host_pkg::REG_STAT: rdata_nxt = {7'h0, wptr_r, status_r, 4'h0,
          status_r[flash_host_pkg::WIP_BIT], refused_r, asleep_r, busy};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr_ok && avs_address == flash_host_pkg::REG_DATA && wptr_r != 9'h100)
      mem[wptr_r[7:0]] <= avs_writedata[7:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r <= 24'h0;
      len_r <= 9'h0;
      wptr_r <= 9'h0;
      rdata_r <= 32'h0;
      rd_ack_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      wptr_r <= wptr_nxt;
      rdata_r <= rdata_nxt;
      rd_ack_r <= rd_ack_nxt;
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  logic fr_start, fr_done;
  flash_host_pkg::frame_t fr_req;
  logic [15:0] wait_r, wait_nxt;
  logic [7:0] rx_byte_r;
  flash_host_pkg::op_t new_op;

  always_comb
  begin
    seq_nxt = seq_r;
    op_nxt = op_r;
    alt_nxt = alt_r;
    asleep_nxt = asleep_r;
    refused_nxt = refused_r;
    status_nxt = status_r;
    wait_nxt = wait_r;
    fr_start = 1'b0;
    fr_req = mk(flash_host_pkg::OPC_STAT_LO, 1'b0, 9'h0, 1'b1);
    new_op = flash_host_pkg::op_t'(avs_writedata[flash_host_pkg::CTRL_OP_LSB +: 3]);
    unique case (seq_r)
      SQ_IDLE:
        if (cmd_go)
        begin
          op_nxt = new_op;
          alt_nxt = avs_writedata[flash_host_pkg::CTRL_ALT_BIT];
          refused_nxt = 1'b0;
          if (avs_writedata[2:0] > flash_host_pkg::OP_CODE_MAX ||
              (asleep_r && new_op != flash_host_pkg::OP_WAKE))
            refused_nxt = 1'b1;
          else if (new_op == flash_host_pkg::OP_PROG &&
                   (len_r == 9'h0 || len_r > flash_host_pkg::PAGE_BYTES))
            refused_nxt = 1'b1;
          else if (new_op == flash_host_pkg::OP_PROG)
          begin
            seq_nxt = SQ_QE;
            fr_start = 1'b1;
            fr_req = mk(flash_host_pkg::OPC_STAT_HI, 1'b0, 9'h0, 1'b1);
          end
          else if (new_op == flash_host_pkg::OP_SLEEP || new_op == flash_host_pkg::OP_WAKE)
          begin
            seq_nxt = SQ_MAIN;
            fr_start = 1'b1;
            fr_req = mk(new_op == flash_host_pkg::OP_SLEEP ? flash_host_pkg::OPC_SLEEP :
              flash_host_pkg::OPC_WAKE, 1'b0, 9'h0, 1'b0);
          end
          else
          begin
            seq_nxt = SQ_WRITE_ENABLE_COMMAND;
            fr_start = 1'b1;
            fr_req = mk(flash_host_pkg::OPC_WRITE_ENABLE_COMMAND, 1'b0, 9'h0, 1'b0);
          end
        end
      SQ_QE:
        if (fr_done)
        begin
          if (rx_byte_r[flash_host_pkg::QE_BIT])
          begin
            seq_nxt = SQ_WRITE_ENABLE_COMMAND;
            fr_start = 1'b1;
            fr_req = mk(flash_host_pkg::OPC_WRITE_ENABLE_COMMAND, 1'b0, 9'h0, 1'b0);
          end
          else
          begin
            seq_nxt = SQ_IDLE;
            refused_nxt = 1'b1;
          end
        end
      SQ_WRITE_ENABLE_COMMAND:
        if (fr_done)
        begin
          seq_nxt = SQ_MAIN;
          fr_start = 1'b1;
          unique case (op_r)
            flash_host_pkg::OP_PROG: fr_req = mk(flash_host_pkg::OPC_QPROG, 1'b1, len_r, 1'b0);
            flash_host_pkg::OP_SECT: fr_req = mk(flash_host_pkg::OPC_SECT, 1'b1, 9'h0, 1'b0);
            flash_host_pkg::OP_BLK32: fr_req = mk(flash_host_pkg::OPC_BLK32, 1'b1, 9'h0, 1'b0);
            flash_host_pkg::OP_BLK64: fr_req = mk(flash_host_pkg::OPC_BLK64, 1'b1, 9'h0, 1'b0);
            default: fr_req = mk(alt_r ? flash_host_pkg::OPC_CHIP_B : flash_host_pkg::OPC_CHIP_A,
              1'b0, 9'h0, 1'b0);
          endcase
        end
      SQ_MAIN:
        if (fr_done)
        begin
          if (op_r == flash_host_pkg::OP_SLEEP)
          begin
            seq_nxt = SQ_WAIT;
            asleep_nxt = 1'b1;
            wait_nxt = flash_host_pkg::SLEEP_ENTRY_CYC - 16'h1;
          end
          else if (op_r == flash_host_pkg::OP_WAKE)
          begin
            seq_nxt = SQ_WAIT;
            asleep_nxt = 1'b0;
            wait_nxt = flash_host_pkg::WAKE_DELAY_CYC - 16'h1;
          end
          else
          begin
            seq_nxt = SQ_POLL;
            fr_start = 1'b1;
          end
        end
      SQ_POLL:
        if (fr_done)
        begin
          status_nxt = rx_byte_r;
          if (rx_byte_r[flash_host_pkg::WIP_BIT])
            fr_start = 1'b1;
          else
            seq_nxt = SQ_IDLE;
        end
      SQ_WAIT:
        if (wait_r == 16'h0)
          seq_nxt = SQ_IDLE;
        else
          wait_nxt = wait_r - 16'h1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_r <= SQ_IDLE;
      op_r <= flash_host_pkg::OP_PROG;
      alt_r <= 1'b0;
      asleep_r <= 1'b0;
      refused_r <= 1'b0;
      status_r <= 8'h0;
      wait_r <= 16'h0;
    end
    else
    begin
      seq_r <= seq_nxt;
      op_r <= op_nxt;
      alt_r <= alt_nxt;
      asleep_r <= asleep_nxt;
      refused_r <= refused_nxt;
      status_r <= status_nxt;
      wait_r <= wait_nxt;
    end
  end

  // ************************************************************
  // frame engine, clock mode 0
  // ************************************************************
  fr_t fr_r, fr_nxt;
  flash_host_pkg::frame_t desc_r, desc_nxt;
  logic [9:0] idx_r, idx_nxt, next_idx, tot;
  logic [2:0] step_r, step_nxt;
  logic [7:0] sh_r, sh_nxt, rx_sh_r, rx_sh_nxt, rx_byte_nxt, next_byte;
  logic quad_r, quad_nxt, next_quad;
  logic [1:0] gap_r, gap_nxt;
  flash_host_pkg::pins_t pins_nxt;

  // frame end, kept apart so a chained start can be taken in the same cycle
  always_comb
    fr_done = (fr_r == FR_GAP) && tick && (gap_r == flash_host_pkg::GAP_TICKS);

  always_comb
  begin
    fr_nxt = fr_r;
    desc_nxt = desc_r;
    idx_nxt = idx_r;
    step_nxt = step_r;
    sh_nxt = sh_r;
    rx_sh_nxt = rx_sh_r;
    rx_byte_nxt = rx_byte_r;
    quad_nxt = quad_r;
    gap_nxt = gap_r;
    pins_nxt = pins;
    tot = frame_len(desc_r);
    next_idx = idx_r + 10'd1;
    next_quad = (next_idx >= hdr_len(desc_r)) &&
      (next_idx < hdr_len(desc_r) + {1'b0, desc_r.n_data});
    if (desc_r.has_addr && next_idx == 10'd1)
      next_byte = addr_r[23:16];
    else if (desc_r.has_addr && next_idx == 10'd2)
      next_byte = addr_r[15:8];
    else if (desc_r.has_addr && next_idx == 10'd3)
      next_byte = addr_r[7:0];
    else if (next_quad)
      next_byte = mem[8'(next_idx - hdr_len(desc_r))];
    else
      next_byte = 8'h00;
    unique case (fr_r)
      FR_IDLE:
        if (fr_start)
        begin
          desc_nxt = fr_req;
          fr_nxt = FR_SEL;
        end
      FR_SEL:
        if (tick)
        begin
          pins_nxt.cs_n = 1'b0;
          idx_nxt = 10'd0;
          step_nxt = 3'h0;
          sh_nxt = desc_r.opcode;
          quad_nxt = 1'b0;
          fr_nxt = FR_SHIFT;
        end
      FR_SHIFT:
        if (tick && !pins.sclk)
        begin
          pins_nxt.sclk = 1'b1;
          rx_sh_nxt = {rx_sh_r[6:0], io1_s2_r};
        end
        else if (tick)
        begin
          pins_nxt.sclk = 1'b0;
          if (step_r == (quad_r ? 3'h1 : 3'h7))
          begin
            // end right after the last bit
            if (idx_r == tot - 10'd1)
            begin
              fr_nxt = FR_GAP;
              gap_nxt = 2'h0;
              quad_nxt = 1'b0;
              if (desc_r.rd)
                rx_byte_nxt = rx_sh_r;
            end
            else
            begin
              idx_nxt = next_idx;
              step_nxt = 3'h0;
              sh_nxt = next_byte;
              quad_nxt = next_quad;
            end
          end
          else
          begin
            step_nxt = step_r + 3'h1;
            sh_nxt = quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
          end
        end
      FR_GAP:
        if (tick)
        begin
          pins_nxt.cs_n = 1'b1;
          gap_nxt = gap_r + 2'h1;
          if (fr_done)
          begin
            // next frame of a command follows without passing through idle
            fr_nxt = fr_start ? FR_SEL : FR_IDLE;
            if (fr_start)
              desc_nxt = fr_req;
          end
        end
    endcase
    // data nibbles on all four pins in the quad phase, else one bit on io0 with io2 and io3 driven high
    pins_nxt.io_o = quad_nxt ? sh_nxt[7:4] : {3'b110, sh_nxt[7]};
    pins_nxt.io_oe = quad_nxt ? 4'hf : 4'hd;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fr_r <= FR_IDLE;
      desc_r <= '0;
      idx_r <= 10'd0;
      step_r <= 3'h0;
      sh_r <= 8'h0;
      rx_sh_r <= 8'h0;
      rx_byte_r <= 8'h0;
      quad_r <= 1'b0;
      gap_r <= 2'h0;
      pins <= '{cs_n: 1'b1, sclk: 1'b0, io_o: 4'hc, io_oe: 4'hd};
    end
    else
    begin
      fr_r <= fr_nxt;
      desc_r <= desc_nxt;
      idx_r <= idx_nxt;
      step_r <= step_nxt;
      sh_r <= sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_byte_r <= rx_byte_nxt;
      quad_r <= quad_nxt;
      gap_r <= gap_nxt;
      pins <= pins_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  quad_gate_a: assert property (fr_start && fr_req.opcode == flash_host_pkg::OPC_QPROG
    |-> seq_r == SQ_WRITE_ENABLE_COMMAND && op_r == flash_host_pkg::OP_PROG && alt_r == alt_nxt)
    else $error("quad program started without quad enable path");
  quad_pins_a: assert property ($rose(quad_r) |-> pins.io_oe == 4'hf
    && $past(idx_r, 1) >= 10'd3 && desc_r.opcode == flash_host_pkg::OPC_QPROG)
    else $error("quad data phase outside a program frame");
  write_enable_command_first_a: assert property (fr_start && seq_r == SQ_WRITE_ENABLE_COMMAND |->
    ##[1:3] fr_r == FR_SEL && desc_r.opcode != flash_host_pkg::OPC_WRITE_ENABLE_COMMAND)
    else $error("main frame not issued after write enable");
  frame_end_a: assert property (fr_r == FR_SHIFT && fr_nxt == FR_GAP |->
    idx_r == frame_len(desc_r) - 10'd1 && pins.sclk && !pins.cs_n)
    else $error("chip select rose before last bit");
  cs_rise_a: assert property ($rose(pins.cs_n) |->
    !pins.sclk && fr_r == FR_GAP && $past(pins.sclk, 1) == 1'b0)
    else $error("chip select rose with clock high");
  poll_loop_a: assert property (seq_r == SQ_POLL && fr_done |=>
    (rx_byte_r[flash_host_pkg::WIP_BIT] ? fr_r == FR_SEL : seq_r == SQ_IDLE))
    else $error("busy poll did not follow status");
  chip_frame_a: assert property (fr_start && (fr_req.opcode == flash_host_pkg::OPC_CHIP_A
    || fr_req.opcode == flash_host_pkg::OPC_CHIP_B
    || fr_req.opcode == flash_host_pkg::OPC_SLEEP)
    |-> !fr_req.has_addr && fr_req.n_data == 9'h0)
    else $error("opcode only frame carries extra bytes");
  sleep_wait_a: assert property (seq_r == SQ_MAIN && fr_done && op_r == flash_host_pkg::OP_SLEEP
    |=> seq_r == SQ_WAIT && asleep_r && wait_r == flash_host_pkg::SLEEP_ENTRY_CYC - 16'h1)
    else $error("sleep entry delay not loaded");
  asleep_refuse_a: assert property (asleep_r && cmd_go && avs_writedata[2:0] != 3'h6
    |=> seq_r == SQ_IDLE && refused_r)
    else $error("command accepted while asleep");
  sleep_idle_a: assert property (fr_start && fr_req.opcode == flash_host_pkg::OPC_SLEEP
    |-> seq_r == SQ_IDLE)
    else $error("deep sleep sent during a device cycle");

endmodule
`default_nettype wire

// ---- flash_host_pkg.sv ----
// constants and types shared by the serial flash host controller
package flash_host_pkg;

  // ************************************************************
  // flash opcodes
  // ************************************************************
  localparam logic [7:0] OPC_WRITE_ENABLE_COMMAND = 8'h06;
  localparam logic [7:0] OPC_QPROG = 8'h32;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_BLK32 = 8'h52;
  localparam logic [7:0] OPC_BLK64 = 8'hd8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hc7;
  localparam logic [7:0] OPC_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_WAKE = 8'hab;
  localparam logic [7:0] OPC_STAT_LO = 8'h05;
  localparam logic [7:0] OPC_STAT_HI = 8'h35;

  // ************************************************************
  // flash status fields and page size
  // ************************************************************
  localparam int WIP_BIT = 0;
  localparam int QE_BIT = 1;
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_LEN = 5'h08;
  localparam logic [4:0] REG_DATA = 5'h0c;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ALT_BIT = 3;
  localparam logic [2:0] OP_CODE_MAX = 3'h6;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
  localparam logic [1:0] GAP_TICKS = 2'h2;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_DELAY_NS = 20000;
  localparam logic [15:0] SLEEP_ENTRY_CYC =
    16'((SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_DELAY_CYC =
    16'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    OP_PROG, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP, OP_SLEEP, OP_WAKE
  } op_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic has_addr;
    logic [8:0] n_data;
    logic rd;
  } frame_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } pins_t;

endpackage

// ---- flash_model.sv ----
// behavioural quad serial flash answering the host controller
`timescale 1ns/1ps
`default_nettype none
module flash_model
#(
  parameter int WAKE_CYC = 150
)
(
  // clock and pins
  input wire logic clk_sys,
  input wire flash_host_pkg::pins_t pins,
  output logic [3:0] io_i,
  // knobs
  input wire logic quad_on,
  input wire logic prot,
  input wire logic [15:0] busy_cyc
);
  // ************************************************************
  // device state
  // ************************************************************
  logic [7:0] mem [int];
  logic [7:0] dq [$];
  logic [7:0] op = '0, last_op = '0, sr = '0, nop;
  logic [3:0] nib = '0;
  logic [23:0] adr = '0, last_adr = '0;
  int nb = 0, wcnt = 0, wk = 0, errs = 0, ncyc = 0;
  logic wlatch = 1'b0, asleep = 1'b0, sk_q = 1'b0, cs_q = 1'b1, so = 1'b0, rdg;

  // released line toggles so a stale bit never reads as valid
  assign io_i = {so, ~so, so, ~so};

  function automatic logic [7:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  task automatic end_frame();
    int sz;
    logic act;
    logic go;
    sz = op == flash_host_pkg::OPC_SECT ? 4096 : op == flash_host_pkg::OPC_BLK32 ? 32768 :
      op == flash_host_pkg::OPC_BLK64 ? 65536 : 0;
    act = 1'b0;
    go = 1'b0;
    // asleep, only a lone wake is heard
    if (asleep)
    begin
      asleep = !(op == flash_host_pkg::OPC_WAKE && nb == 8);
      wk = asleep ? 0 : WAKE_CYC;
    end
    else if (op == flash_host_pkg::OPC_WRITE_ENABLE_COMMAND && nb == 8)
      wlatch = 1'b1;
    else if (op == flash_host_pkg::OPC_SLEEP)
      asleep = nb == 8 && wcnt == 0;
    else if (op == flash_host_pkg::OPC_QPROG)
    begin
      act = 1'b1;
      go = quad_on && nb >= 34 && nb % 2 == 0;
    end
    else if (sz != 0 || op == flash_host_pkg::OPC_CHIP_A || op == flash_host_pkg::OPC_CHIP_B)
    begin
      act = 1'b1;
      go = nb == (sz != 0 ? 32 : 8);
    end
    if (act && !(go && wlatch))
      errs++;
    // no cycle unless enabled and unprotected
    if (act && go && wlatch && !prot)
    begin
      // bytes into the page, wrapping at its end
      foreach (dq[i])
        mem[{adr[23:8], 8'(adr[7:0] + i)}] = peek({adr[23:8], 8'(adr[7:0] + i)}) & dq[i];
      // any address picks the whole unit
      for (int i = 0; i < sz; i++)
        mem.delete(adr / sz * sz + i);
      if (sz == 0 && op != flash_host_pkg::OPC_QPROG)
        mem.delete();
      // busy for the cycle, latch cleared
      wcnt = busy_cyc;
      wlatch = 1'b0;
      ncyc++;
      last_op = op;
      last_adr = adr;
    end
  endtask

  always @(posedge clk_sys)
  begin
    nop = {op[6:0], pins.io_o[0]};
    rdg = !pins.cs_n && nb >= 8 && !asleep &&
      (op == flash_host_pkg::OPC_STAT_LO || op == flash_host_pkg::OPC_STAT_HI);
    if (wcnt > 0)
      wcnt--;
    if (wk > 0)
      wk--;
    if (!pins.cs_n && cs_q && wk > 0)
      errs++;
    if (rdg && !pins.sclk && sk_q)
    begin
      so <= sr[7];
      sr = {sr[6:0], 1'b0};
    end
    else if (!rdg)
      so <= ~so;
    if (pins.cs_n && !cs_q)
    begin
      end_frame();
      nb = 0;
      dq.delete();
    end
    else if (!pins.cs_n && pins.sclk && !sk_q)
    begin
      if (nb < 8)
        op = nop;
      else if (nb < 32)
        adr = {adr[22:0], pins.io_o[0]};
      else if (nb % 2 == 0)
        nib = pins.io_o;
      else
        dq.push_back({nib, pins.io_o});
      // only the last 256 bytes are kept
      if (dq.size() > 256)
        dq.pop_front();
      if (nb == 7)
        sr = nop == flash_host_pkg::OPC_STAT_LO ? {6'h00, wlatch, wcnt > 0} :
          {6'h00, quad_on, 1'b0};
      nb++;
    end
    sk_q = pins.sclk;
    cs_q = pins.cs_n;
  end
endmodule
`default_nettype wire

// ---- serial_flash_program_erase_powerdown_tb.sv ----
// self-checking bench for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module serial_flash_program_erase_powerdown_tb;
  // ************************************************************
  // bench
  // ************************************************************
  logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q, x;
  flash_host_pkg::pins_t pins;
  logic [3:0] io_i;
  logic quad_on = 1'b1, prot = 1'b0;
  logic [15:0] busy_cyc = 16'h0028;
  logic [23:0] a;
  logic [7:0] dat [256];
  logic [7:0] opc [4] = '{8'h00, flash_host_pkg::OPC_SECT, flash_host_pkg::OPC_BLK32,
    flash_host_pkg::OPC_BLK64};
  int fails = 0, cmp_count = 0, cyc = 0, n0;

  always #50 clk_sys = ~clk_sys;

  flash_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins), .io_i(io_i));
  flash_model u_flash (.clk_sys(clk_sys), .pins(pins), .io_i(io_i), .quad_on(quad_on),
    .prot(prot), .busy_cyc(busy_cyc));

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    logic hold;
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk_sys);
      hold = avs_waitrequest;
      q = avs_readdata;
    end
    while (hold !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic run(input logic [31:0] c, input logic [23:0] ad);
    bus(1, flash_host_pkg::REG_ADDR, 32'(ad));
    bus(1, flash_host_pkg::REG_CTRL, c);
    do
      bus(0, flash_host_pkg::REG_STAT, 0);
    while (q[0] !== 1'b0);
  endtask

  task automatic prog(input logic [23:0] ad, input int n);
    n0 = u_flash.ncyc;
    bus(1, flash_host_pkg::REG_LEN, n);
    for (int i = 0; i < n; i++)
    begin
      dat[i] = 8'($urandom);
      bus(1, flash_host_pkg::REG_DATA, 32'(dat[i]));
    end
    run(0, ad);
    chk(q[2], !quad_on);
    chk(u_flash.ncyc - n0, quad_on && !prot);
    for (int i = 0; i < n; i++)
      chk(u_flash.peek({ad[23:8], 8'(ad[7:0] + i)}), quad_on && !prot ? dat[i] : 8'hff);
  endtask

  initial
  begin
    q = $urandom(32'h7b48aaf7);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(0, 5'h14, 0);
    x = q;
    bus(0, flash_host_pkg::REG_STAT, 0);
    chk(q | x, 0);
    prog(24'h0001f0, 256);
    for (int k = 2; k < 5; k++)
      prog({8'h00, 8'(k), 8'($urandom)}, 1 + $urandom % 256);
    for (int c = 1; c < 4; c++)
    begin
      a = {8'h00, 8'(c + 1), 8'($urandom)};
      run(c, a);
      chk(u_flash.last_op, opc[c]);
      chk(u_flash.last_adr, a);
      chk(u_flash.peek({a[23:8], 8'($urandom)}), 8'hff);
    end
    for (int c = 0; c < 2; c++)
    begin
      run(4 + 8 * c, 0);
      chk(u_flash.last_op, c ? flash_host_pkg::OPC_CHIP_B : flash_host_pkg::OPC_CHIP_A);
    end
    chk(u_flash.peek(32'h0001f0), 8'hff);
    quad_on <= 1'b0;
    prog(24'h000500, 16);
    quad_on <= 1'b1;
    prot <= 1'b1;
    prog(24'h000600, 16);
    n0 = u_flash.ncyc;
    run(1, 24'h000600);
    run(4, 0);
    chk(u_flash.ncyc - n0, 0);
    prot <= 1'b0;
    run(5, 0);
    chk({q[1], u_flash.asleep}, 2'h3);
    run(1, 0);
    chk(q[2], 1);
    run(6, 0);
    chk({q[1], u_flash.asleep}, 0);
    bus(1, flash_host_pkg::REG_LEN, 0);
    run(0, 0);
    chk(q[2], 1);
    busy_cyc <= 16'h0bb8;
    bus(1, flash_host_pkg::REG_ADDR, 32'h000700);
    bus(1, flash_host_pkg::REG_LEN, 1);
    bus(1, flash_host_pkg::REG_DATA, 32'h5a);
    bus(1, flash_host_pkg::REG_CTRL, 0);
    run(5, 24'h000700);
    chk(u_flash.asleep, 1);
    chk(u_flash.peek(32'h000700), 8'h5a);
    run(6, 0);
    chk(u_flash.errs, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
